// ===== afepmc_host_model.sv
// Host model driving the power pins and transmit trigger
`timescale 1ns/100ps
module afepmc_host_model (
    // Clock
    input wire logic clk_in,
    // Pins toward the device
    output logic power_down_pin_out,
    output logic standby_pin_out,
    output logic transmit_trigger_out
);
    // Pins idle low so the device starts in normal operation
    initial begin
        power_down_pin_out = 1'b0;
        standby_pin_out = 1'b0;
        transmit_trigger_out = 1'b0;
    end
    // Levels change just after an edge and then hold
    task automatic set_pins(input logic pd, input logic sb);
        @(posedge clk_in);
        power_down_pin_out <= pd;
        standby_pin_out <= sb;
    endtask : set_pins
    // Held 4 cycles so the two-stage synchroniser cannot miss it
    task automatic trigger();
        @(posedge clk_in);
        transmit_trigger_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        transmit_trigger_out <= 1'b0;
    endtask : trigger
    // Full wake budget before relying on data after power-down
    task automatic settle();
        repeat (afepmc_pkg::PD_WAKE_CYC_I) @(posedge clk_in);
    endtask : settle
endmodule : afepmc_host_model

// ===== afepmc_pkg.sv
// Shared constants, register map and types for the front-end power mode controller
package afepmc_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 10;
    localparam int PD_WAKE_US = 375;
    localparam int SB_WAKE_US = 2;
    localparam int PD_WAKE_CYC_I = PD_WAKE_US * CLK_FREQ_MHZ;
    localparam int SB_WAKE_CYC_I = SB_WAKE_US * CLK_FREQ_MHZ;
    localparam logic [11:0] PD_WAKE_CYC = 12'(PD_WAKE_CYC_I);
    localparam logic [11:0] SB_WAKE_CYC = 12'(SB_WAKE_CYC_I);
    localparam logic [3:0] DLL_RELOCK_CYC = 4'h8;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int NCH = 8;

    // ------------------------------------------------------------------
    // Register offsets and fields
    // ------------------------------------------------------------------
    localparam logic [11:0] REG_CTRL = 12'h008;
    localparam logic [11:0] REG_SETUP = 12'h110;
    localparam logic [11:0] REG_START = 12'h112;
    localparam logic [11:0] REG_STOP = 12'h113;
    localparam logic [11:0] REG_STATUS = 12'h114;
    localparam int CTRL_CHPD_LSB = 0;
    localparam int CTRL_SBY_BIT = 8;
    localparam int CTRL_DCS_BIT = 9;
    localparam int CTRL_PROF_BIT = 10;
    localparam int CTRL_RATE_BIT = 11;
    localparam int SETUP_AWARM_BIT = 0;
    localparam logic [15:0] CTRL_RST = 16'h0200;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [11:0] WCNT_ONE = 12'h001;
    localparam logic [3:0] RELOCK_ONE = 4'h1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_ACTIVE = 3'b000,
        ST_PDOWN = 3'b001,
        ST_PDWAKE = 3'b010,
        ST_STANDBY_PIN = 3'b011,
        ST_SBWAKE = 3'b100
    } afepmc_state_type;

    typedef struct packed {
        logic refs;
        logic ref_buf;
        logic pll;
        logic bias;
    } afepmc_pwr_type;

    typedef struct packed {
        logic [4:0] rsvd;
        logic prof_run;
        logic valid;
        logic locked;
        logic oe;
        afepmc_pwr_type pwr;
        logic [2:0] state;
    } afepmc_status_type;

endpackage : afepmc_pkg

// ===== afepmc_sync2.sv
// Two flip-flop synchroniser for one asynchronous pin level
`timescale 1ns/100ps
module afepmc_sync2 (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Pin level and its synchronised copy
    input wire logic async_in,
    output logic sync_out
);

    logic meta_r;

    // Only the second stage is visible to other logic
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            meta_r <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : afepmc_sync2

// ===== afepmc_top.sv
// Power mode sequencer, channel power profile and stabilizer relock control
//
// Contract
// RULE_01: Power-down pin high puts device deepest off: references, buffer, PLL, bias off.
// RULE_02: In power-down all serial data output drivers are high impedance.
// RULE_03: Power-down pin low makes device leave power-down and resume operation.
// RULE_04: Standby pin high powers everything down except internal references. Code also keeps the reference buffer on in standby.
// RULE_05: In standby all serial data output drivers are high impedance.
// RULE_06: Standby pin low makes device leave standby and return to operation.
// RULE_07: Host allows about 375 us after power-down release before relying on data.
// RULE_08: Wake-up delay after power-down scales with time spent powered down.
// RULE_09: Software may power down each channel or place whole device in standby.
// RULE_10: Software standby keeps the PLL running; recovery takes about 2 us.
// RULE_11: Enabled stabilizer retimes non-sampling edge for nominal 50% duty cycle.
// RULE_12: Stabilizer can be switched off; input edges then used directly.
// RULE_13: After a rate change the loop needs eight cycles; data then untrusted.
// RULE_14: Channels power up after start count, turn off after stop count samples.
// RULE_15: Start and stop counters count from the transmit trigger event.
// RULE_16: Analog powers before digital; warm-up set before start count programmed.
// RULE_17: Samples and sample counts are taken on the rising clock edge.
// RULE_18: Pins are synchronised; power-down wins over standby when both high.
`timescale 1ns/100ps
module afepmc_top (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Register port
    input wire logic [11:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    // Host pins
    input wire logic power_down_pin_in,
    input wire logic standby_pin_in,
    input wire logic transmit_trigger_in,
    // Supply, analog and digital channel power controls
    output afepmc_pkg::afepmc_pwr_type pwr_en_out,
    output logic [7:0] chan_analog_en_out,
    output logic [7:0] chan_digital_en_out,
    // Output drivers and clock stabilizer
    output logic lvds_oe_out,
    output logic dcs_retime_out,
    output logic dll_locked_out,
    output logic data_valid_out
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic pd_s;
    logic sby_s;
    logic trig_s;
    logic trig_d_r;
    logic trig_rise;
    logic [15:0] ctrl_r;
    logic awarm_r;
    logic [15:0] start_cnt_r;
    logic [15:0] stop_cnt_r;
    logic rate_chg_r;
    logic [7:0] chan_pd;
    logic soft_sby;
    logic dcs_en;
    logic prof_en;
    logic sby_any;
    logic wr_ctrl;
    logic wr_start;
    afepmc_pkg::afepmc_state_type state_r;
    logic [11:0] wake_cnt_r;
    logic [11:0] pd_time_r;
    logic [3:0] relock_cnt_r;
    logic wake_done;
    afepmc_pkg::afepmc_pwr_type pwr_nxt;
    afepmc_pkg::afepmc_pwr_type pwr_r;
    logic oe_r;
    logic [15:0] sample_cnt_r;
    logic prof_run_r;
    logic in_window;
    logic [7:0] chan_analog_nxt;
    logic [7:0] chan_analog_r;
    logic [7:0] chan_digital_r;
    logic [15:0] rdata_r;
    afepmc_pkg::afepmc_status_type status;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    afepmc_sync2 u_sync_pd (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in(power_down_pin_in),
        .sync_out(pd_s)
    ); // [RULE_18]

    afepmc_sync2 u_sync_sby (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in(standby_pin_in),
        .sync_out(sby_s)
    ); // [RULE_18]

    afepmc_sync2 u_sync_trig (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in(transmit_trigger_in),
        .sync_out(trig_s)
    );

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    assign chan_pd = ctrl_r[afepmc_pkg::CTRL_CHPD_LSB +: afepmc_pkg::NCH];
    assign soft_sby = ctrl_r[afepmc_pkg::CTRL_SBY_BIT];
    assign dcs_en = ctrl_r[afepmc_pkg::CTRL_DCS_BIT];
    assign prof_en = ctrl_r[afepmc_pkg::CTRL_PROF_BIT];
    assign sby_any = sby_s | soft_sby; // [RULE_09]
    assign wr_ctrl = reg_wr_in && (reg_addr_in == afepmc_pkg::REG_CTRL);
    assign wr_start = reg_wr_in && (reg_addr_in == afepmc_pkg::REG_START);

    // Writable controls; the rate-change bit is a strobe and never stored
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ctrl_r <= afepmc_pkg::CTRL_RST;
            awarm_r <= 1'b0;
            stop_cnt_r <= afepmc_pkg::CNT_RST;
            rate_chg_r <= 1'b0;
        end else begin
            rate_chg_r <= wr_ctrl && reg_wdata_in[afepmc_pkg::CTRL_RATE_BIT];
            if (wr_ctrl) begin
                ctrl_r <= reg_wdata_in & ~(16'h0001 << afepmc_pkg::CTRL_RATE_BIT);
            end
            if (reg_wr_in && (reg_addr_in == afepmc_pkg::REG_SETUP)) begin
                awarm_r <= reg_wdata_in[afepmc_pkg::SETUP_AWARM_BIT];
            end
            if (reg_wr_in && (reg_addr_in == afepmc_pkg::REG_STOP)) begin
                stop_cnt_r <= reg_wdata_in;
            end
        end
    end

    // Start count is refused until analog warm-up is set, so digital never leads
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            start_cnt_r <= afepmc_pkg::CNT_RST;
        end else if (wr_start && awarm_r) begin // [RULE_16]
            start_cnt_r <= reg_wdata_in;
        end
    end

    // Status view of the sequencer
    always_comb begin
        status = '0;
        status.state = state_r;
        status.pwr = pwr_r;
        status.oe = oe_r;
        status.locked = dll_locked_out;
        status.valid = data_valid_out;
        status.prof_run = prof_run_r;
    end

    // Read data stand one cycle after the strobe only; unmapped reads return zero
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !reg_rd_in) begin
            rdata_r <= 16'h0000;
        end else begin
            case (reg_addr_in)
                afepmc_pkg::REG_CTRL: rdata_r <= ctrl_r;
                afepmc_pkg::REG_SETUP: rdata_r <= {15'h0000, awarm_r};
                afepmc_pkg::REG_START: rdata_r <= start_cnt_r;
                afepmc_pkg::REG_STOP: rdata_r <= stop_cnt_r;
                afepmc_pkg::REG_STATUS: rdata_r <= status;
                default: rdata_r <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Power mode sequencer
    // ------------------------------------------------------------------
    // Power-down is checked first in every state so it always wins
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_r <= afepmc_pkg::ST_ACTIVE;
            wake_cnt_r <= 12'h000;
        end else begin
            case (state_r)
                afepmc_pkg::ST_ACTIVE: begin
                    if (pd_s) begin
                        state_r <= afepmc_pkg::ST_PDOWN; // [RULE_01] [RULE_18]
                    end else if (sby_any) begin
                        state_r <= afepmc_pkg::ST_STANDBY_PIN; // [RULE_04] [RULE_09]
                    end
                end
                afepmc_pkg::ST_PDOWN: begin
                    if (!pd_s) begin
                        state_r <= afepmc_pkg::ST_PDWAKE; // [RULE_03]
                        wake_cnt_r <= pd_time_r + afepmc_pkg::WCNT_ONE; // [RULE_08]
                    end
                end
                afepmc_pkg::ST_PDWAKE, afepmc_pkg::ST_SBWAKE: begin
                    if (pd_s) begin
                        state_r <= afepmc_pkg::ST_PDOWN;
                    end else if (sby_any) begin
                        state_r <= afepmc_pkg::ST_STANDBY_PIN;
                    end else if (wake_cnt_r <= afepmc_pkg::WCNT_ONE) begin
                        state_r <= afepmc_pkg::ST_ACTIVE;
                    end else begin
                        wake_cnt_r <= wake_cnt_r - afepmc_pkg::WCNT_ONE;
                    end
                end
                afepmc_pkg::ST_STANDBY_PIN: begin
                    if (pd_s) begin
                        state_r <= afepmc_pkg::ST_PDOWN;
                    end else if (!sby_any) begin
                        state_r <= afepmc_pkg::ST_SBWAKE; // [RULE_06]
                        wake_cnt_r <= afepmc_pkg::SB_WAKE_CYC; // [RULE_10]
                    end
                end
                default: begin
                    state_r <= afepmc_pkg::ST_ACTIVE;
                end
            endcase
        end
    end

    // Time spent powered down, capped at the full reference recharge time
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || state_r != afepmc_pkg::ST_PDOWN) begin
            pd_time_r <= 12'h000;
        end else if (pd_time_r < afepmc_pkg::PD_WAKE_CYC - afepmc_pkg::WCNT_ONE) begin
            pd_time_r <= pd_time_r + afepmc_pkg::WCNT_ONE; // [RULE_08] [RULE_07]
        end
    end

    assign wake_done = (state_r == afepmc_pkg::ST_PDWAKE || state_r == afepmc_pkg::ST_SBWAKE) &&
                       !pd_s && !sby_any && (wake_cnt_r <= afepmc_pkg::WCNT_ONE);

    // Supply network enables per state; software standby keeps the PLL alive
    always_comb begin
        pwr_nxt = '0;
        case (state_r)
            afepmc_pkg::ST_ACTIVE, afepmc_pkg::ST_PDWAKE, afepmc_pkg::ST_SBWAKE: begin
                pwr_nxt = '1;
            end
            afepmc_pkg::ST_STANDBY_PIN: begin
                pwr_nxt.refs = 1'b1; // [RULE_04]
                pwr_nxt.ref_buf = 1'b1;
                pwr_nxt.pll = !sby_s; // [RULE_10]
            end
            default: begin
                pwr_nxt = '0; // [RULE_01]
            end
        endcase
    end

    // Drivers float in power-down and standby
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pwr_r <= '0;
            oe_r <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            oe_r <= (state_r != afepmc_pkg::ST_PDOWN) && (state_r != afepmc_pkg::ST_STANDBY_PIN); // [RULE_02] [RULE_05]
        end
    end

    // ------------------------------------------------------------------
    // Duty cycle stabilizer relock
    // ------------------------------------------------------------------
    // The rate cannot be seen here, so software flags a change; wake-up also relocks
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            relock_cnt_r <= afepmc_pkg::DLL_RELOCK_CYC;
        end else if (wr_ctrl && reg_wdata_in[afepmc_pkg::CTRL_DCS_BIT] && !dcs_en) begin
            relock_cnt_r <= afepmc_pkg::DLL_RELOCK_CYC; // [RULE_13]
        end else if (!dcs_en) begin
            relock_cnt_r <= 4'h0; // [RULE_12]
        end else if (rate_chg_r || wake_done) begin
            relock_cnt_r <= afepmc_pkg::DLL_RELOCK_CYC; // [RULE_13]
        end else if (relock_cnt_r != 4'h0) begin
            relock_cnt_r <= relock_cnt_r - afepmc_pkg::RELOCK_ONE;
        end
    end

    // ------------------------------------------------------------------
    // Channel power profile
    // ------------------------------------------------------------------
    assign trig_rise = trig_s && !trig_d_r;

    // Sample counter restarts on every trigger and stops at its ceiling
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            trig_d_r <= 1'b0;
            sample_cnt_r <= afepmc_pkg::CNT_RST;
            prof_run_r <= 1'b0;
        end else begin
            trig_d_r <= trig_s;
            if (!prof_en) begin
                prof_run_r <= 1'b0;
                sample_cnt_r <= afepmc_pkg::CNT_RST;
            end else if (trig_rise) begin
                prof_run_r <= 1'b1; // [RULE_15]
                sample_cnt_r <= afepmc_pkg::CNT_RST;
            end else if (prof_run_r && sample_cnt_r != afepmc_pkg::CNT_MAX) begin
                sample_cnt_r <= sample_cnt_r + 16'h0001; // [RULE_17]
            end
        end
    end

    // A stop count of zero means the channel stays on until the next trigger
    assign in_window = !prof_en || (prof_run_r && (sample_cnt_r >= start_cnt_r) &&
                       ((stop_cnt_r == afepmc_pkg::CNT_RST) || (sample_cnt_r < stop_cnt_r))); // [RULE_14]
    assign chan_analog_nxt = (pwr_nxt.bias && in_window) ? ~chan_pd : 8'h00; // [RULE_09]

    // Digital follows analog one cycle later on power-up and drops with it
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            chan_analog_r <= 8'h00;
            chan_digital_r <= 8'h00;
        end else begin
            chan_analog_r <= chan_analog_nxt;
            chan_digital_r <= chan_analog_r & chan_analog_nxt; // [RULE_16]
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata_out = rdata_r;
    assign pwr_en_out = pwr_r;
    assign chan_analog_en_out = chan_analog_r;
    assign chan_digital_en_out = chan_digital_r;
    assign lvds_oe_out = oe_r;
    assign dcs_retime_out = dcs_en; // [RULE_11] [RULE_12]
    assign dll_locked_out = (relock_cnt_r == 4'h0);
    assign data_valid_out = oe_r && (state_r == afepmc_pkg::ST_ACTIVE) && dll_locked_out; // [RULE_13]

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    pd_entry_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        pd_s |=> state_r == afepmc_pkg::ST_PDOWN) else $error("power-down pin not obeyed"); // [RULE_01] [RULE_18]
    pd_all_off_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        state_r == afepmc_pkg::ST_PDOWN |=> pwr_en_out == '0) else $error("supplies on in power-down"); // [RULE_01]
    pd_hiz_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        state_r == afepmc_pkg::ST_PDOWN |=> !lvds_oe_out) else $error("drivers on in power-down"); // [RULE_02]
    pd_exit_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        state_r == afepmc_pkg::ST_PDOWN && !pd_s |=> state_r == afepmc_pkg::ST_PDWAKE) else $error("no exit"); // [RULE_03]
    sby_refs_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        state_r == afepmc_pkg::ST_STANDBY_PIN |=> pwr_en_out.refs && !pwr_en_out.bias && !lvds_oe_out)
        else $error("standby power wrong"); // [RULE_04] [RULE_05]
    sby_exit_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        state_r == afepmc_pkg::ST_STANDBY_PIN && !pd_s && !sby_any |=> state_r == afepmc_pkg::ST_SBWAKE &&
        wake_cnt_r == afepmc_pkg::SB_WAKE_CYC) else $error("standby exit wrong"); // [RULE_06] [RULE_10]
    wake_scale_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        state_r == afepmc_pkg::ST_PDOWN && !pd_s |=> wake_cnt_r == $past(pd_time_r) + afepmc_pkg::WCNT_ONE)
        else $error("wake delay not scaled"); // [RULE_08]
    soft_pll_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        state_r == afepmc_pkg::ST_STANDBY_PIN && !sby_s |=> pwr_en_out.pll) else $error("pll off in soft standby"); // [RULE_10]
    chan_pd_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        1'b1 |=> (chan_analog_en_out & $past(chan_pd)) == 8'h00) else $error("channel not powered down"); // [RULE_09]
    dcs_relock_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        rate_chg_r && dcs_en |=> !dll_locked_out [*8] ##1 (dll_locked_out || rate_chg_r || wake_done))
        else $error("relock length wrong"); // [RULE_13]
    dcs_off_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !dcs_en |=> dll_locked_out || dcs_en) else $error("loop active with stabilizer off"); // [RULE_11] [RULE_12]
    start_gate_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_start && !awarm_r |=> $stable(start_cnt_r)) else $error("start count taken before warm-up"); // [RULE_16]
    an_first_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        1'b1 |=> (chan_digital_en_out & ~$past(chan_analog_r)) == 8'h00) else $error("digital before analog"); // [RULE_16]
    trig_count_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        prof_en && trig_rise |=> sample_cnt_r == afepmc_pkg::CNT_RST ##1
        (sample_cnt_r == 16'h0001 || !prof_en || trig_rise)) else $error("count not from trigger"); // [RULE_15] [RULE_17]
    early_off_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        prof_en && sample_cnt_r < start_cnt_r |=> chan_analog_en_out == 8'h00) else $error("channel on early"); // [RULE_14]

endmodule : afepmc_top

// ===== tb_top.sv
// Self-checking bench for the front-end power mode controller
`timescale 1ns/100ps
module tb_top;
    // Bench state, all inputs defined at time zero
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [11:0] a_r = 12'h000;
    logic [15:0] wd_r = 16'h0000;
    logic wr_r = 1'b0;
    logic rd_r = 1'b0;
    logic [15:0] rdata, v, s, e;
    logic pd, sb, trig, oe, duty_cycle_stabilizer, lock, valid;
    afepmc_pkg::afepmc_pwr_type pwr;
    logic [7:0] ach, dch, mask;
    int err_count = 0;
    int comparisons = 0;
    int n, m;
    afepmc_host_model host (.clk_in(clk_in), .power_down_pin_out(pd), .standby_pin_out(sb),
        .transmit_trigger_out(trig));
    afepmc_top dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(a_r), .reg_wdata_in(wd_r),
        .reg_wr_in(wr_r), .reg_rd_in(rd_r), .reg_rdata_out(rdata), .power_down_pin_in(pd),
        .standby_pin_in(sb), .transmit_trigger_in(trig), .pwr_en_out(pwr), .chan_analog_en_out(ach),
        .chan_digital_en_out(dch), .lvds_oe_out(oe), .dcs_retime_out(duty_cycle_stabilizer), .dll_locked_out(lock),
        .data_valid_out(valid));
    // 100 ns sample clock
    always #50 clk_in = ~clk_in;
    // Case equality so an unknown never matches
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Register bus cycles, one strobe cycle each
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk_in);
        wr_r <= 1'b1;
        a_r <= a;
        wd_r <= d;
        @(posedge clk_in);
        wr_r <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge clk_in);
        rd_r <= 1'b1;
        a_r <= a;
        @(posedge clk_in);
        rd_r <= 1'b0;
        #1 d = rdata;
    endtask : rd
    // Sampling 1 ns after the edge lets registered outputs settle
    task automatic step(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask : step
    task automatic wait_valid(output int c);
        c = 0;
        do begin
            step(1);
            c++;
        end while (valid !== 1'b1 && c < 5000);
    endtask : wait_valid
    // Counts unlocked cycles in a fixed window; a rate strobe relocks one cycle after an enable write
    task automatic relock(input logic [15:0] d);
        int c;
        wr(afepmc_pkg::REG_CTRL, d);
        c = 0;
        #1;
        repeat (12) begin
            if (lock !== 1'b1) c++;
            step(1);
        end
        chk(16'(c), 16'h0008);
    endtask : relock
    task automatic pd_run(input int hold, output int c);
        host.set_pins(1'b1, 1'b0);
        step(hold);
        chk(16'(pwr), 16'h0000);
        chk(16'(oe), 16'h0000);
        host.set_pins(1'b0, 1'b0);
        wait_valid(c);
        chk(16'(pwr), 16'h000f);
    endtask : pd_run
    task automatic print_verdict();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // Main sequence; wake cost difference isolates the power-down time
    initial begin
        void'($urandom(97346));
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        wait_valid(n);
        rd(afepmc_pkg::REG_CTRL, v);
        chk(v, afepmc_pkg::CTRL_RST);
        rd(afepmc_pkg::REG_STATUS, v);
        chk(v, 16'h03f8);
        rd(12'h7ff, v);
        chk(v, 16'h0000);
        pd_run(40, n);
        pd_run(200, m);
        host.settle();
        chk(16'(m - n), 16'h00a0);
        host.set_pins(1'b0, 1'b1);
        step(6);
        chk({11'h000, oe, pwr}, 16'h000c);
        host.set_pins(1'b1, 1'b1);
        step(6);
        chk(16'(pwr), 16'h0000);
        host.set_pins(1'b0, 1'b0);
        wait_valid(n);
        wr(afepmc_pkg::REG_CTRL, 16'h0300);
        step(4);
        chk({11'h000, oe, pwr}, 16'h000e);
        wr(afepmc_pkg::REG_CTRL, 16'h0200);
        wait_valid(n);
        chk(16'(n <= 40), 16'h0001);
        for (int i = 0; i < 4; i++) begin
            mask = (i == 0) ? 8'hff : 8'($urandom);
            wr(afepmc_pkg::REG_CTRL, {8'h02, mask});
            step(4);
            chk({ach, dch}, {~mask, ~mask});
        end
        wr(afepmc_pkg::REG_CTRL, 16'h0000);
        step(2);
        chk({duty_cycle_stabilizer, lock}, 16'h0001);
        relock(16'h0200);
        relock(16'h0a00);
        s = 16'h0003 + 16'($urandom % 8);
        e = s + 16'h0005 + 16'($urandom % 20);
        wr(afepmc_pkg::REG_START, s);
        rd(afepmc_pkg::REG_START, v);
        chk(v, 16'h0000);
        wr(afepmc_pkg::REG_SETUP, 16'h0001);
        wr(afepmc_pkg::REG_START, s);
        wr(afepmc_pkg::REG_STOP, e);
        wr(afepmc_pkg::REG_CTRL, 16'h0600);
        step(4);
        chk(16'(ach), 16'h0000);
        fork
            host.trigger();
        join_none
        n = 0;
        while (ach === 8'h00 && n < 200) begin
            step(1);
            n++;
        end
        chk({8'h00, dch}, 16'h0000);
        chk(16'(n > int'(s)), 16'h0001);
        m = 0;
        while (ach === 8'hff && m < 200) begin
            step(1);
            m++;
        end
        chk(16'(m), e - s);
        print_verdict();
    end
    // Watchdog far beyond the few thousand cycles the tests need
    initial begin
        #2000000;
        err_count++;
        print_verdict();
    end
endmodule : tb_top
